/* File: core/frp_pkg.sv */
// Contract
// - 264-byte mode: 5 dummy, 10 page, 9 byte
// - 256-byte mode: 6 dummy, 10 page, 8 byte
// - Accept 1..page bytes, wrap to zero
// - CS rise: read page, merge, erase, program
// - CS mid-byte aborts, nothing programmed
// - Busy flag held during self-timed reprogramming
// - Failing byte sets erase/program error flag
// - No data bytes: automatic page rewrite
// - Software protection off after reset
// - Enable sequence turns protection on
// - Disable sequence clears software protection
// - WP low: protected sectors, register read-only
// - WP asserts/releases protection within bounded delay
// - Enable before/during WP survives release
// - Disable ignored while WP asserted
// - WP only ever adds protection
// - WP input filtered against glitches
// - Status shows protection enabled
// - Per-sector bytes: FFh protected, 00h not
package frp_pkg;

  localparam logic [7:0] OP_RMW          = 8'h58;
  localparam logic [7:0] OP_PROT_B1      = 8'h3D;
  localparam logic [7:0] OP_PROT_B2      = 8'h2A;
  localparam logic [7:0] OP_PROT_B3      = 8'h7F;
  localparam logic [7:0] OP_PROT_ENABLE  = 8'hA9;
  localparam logic [7:0] OP_PROT_DISABLE = 8'h9A;
  localparam logic [7:0] SECT_PROTECTED  = 8'hFF;

  localparam logic [8:0] PAGE_BYTES_STD  = 9'h100;
  localparam logic [8:0] PAGE_BYTES_EXT  = 9'h108;
  localparam int         BUF_BYTES       = 264;
  localparam int         EXT_PAGE_LSB    = 9;
  localparam int         STD_PAGE_LSB    = 8;
  localparam int         SECT_LSB        = 7;
  localparam logic [9:0] SECT0A_LAST_PG  = 10'h007;
  localparam int         SECT0A_MSB      = 7;
  localparam int         SECT0B_MSB      = 5;
  localparam logic [2:0] ADDR_DONE_NB    = 3'h4;

  localparam int CLK_PERIOD_NS           = 100;
  localparam int PROTECT_ENABLE_DELAY_NS = 1000;
  localparam int PROTECT_DISABLE_DELAY_NS = 1000;
  localparam int PROTECT_ENABLE_CYCLES   =
    (PROTECT_ENABLE_DELAY_NS / CLK_PERIOD_NS < 1) ? 1 : PROTECT_ENABLE_DELAY_NS / CLK_PERIOD_NS;
  localparam int PROTECT_DISABLE_CYCLES  =
    (PROTECT_DISABLE_DELAY_NS / CLK_PERIOD_NS < 1) ? 1 : PROTECT_DISABLE_DELAY_NS / CLK_PERIOD_NS;
  localparam int PAGE_PROGRAM_TIME_US    = 3000;
  localparam int PAGE_PROGRAM_CYCLES     = PAGE_PROGRAM_TIME_US * 1000 / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_READ,
    ST_ERASE,
    ST_PROG,
    ST_WAIT
  } frp_state_e;

  typedef struct packed {
    logic       rd;
    logic       erase;
    logic       wr;
    logic [9:0] page;
    logic [8:0] byte_sel;
    logic [7:0] wdata;
  } frp_mem_req_s;

  typedef struct packed {
    logic busy;
    logic erase_program_error_flag;
    logic protect;
    logic prot_reg_writable;
  } frp_status_s;

endpackage : frp_pkg

/* File: core/frp_flash_rmw_protect.sv */
module frp_flash_rmw_protect #(
  parameter int PROG_CYCLES = frp_pkg::PAGE_PROGRAM_CYCLES
) (
  input  wire logic                 clk_i,
  input  wire logic                 reset_i,
  input  wire logic                 sck_i,
  input  wire logic                 cs_n_i,
  input  wire logic                 si_i,
  input  wire logic                 wp_n_i,
  input  wire logic                 page264_i,
  input  wire logic [7:0][7:0]      sector_prot_i,
  input  wire logic [7:0]           mem_rdata_i,
  input  wire logic                 mem_fail_i,
  output frp_pkg::frp_mem_req_s     mem_o,
  output frp_pkg::frp_status_s      status_o
);

  if (PROG_CYCLES < 1 || PROG_CYCLES > 65535) begin : g_chk
    $error("PROG_CYCLES out of range");
  end

  // Link domain: cleared by chip select so every frame starts on a byte
  typedef struct packed {
    logic [2:0] bitcnt;
    logic [6:0] shift;
  } frp_lnk_s;

  // Link domain, reset only by reset_i: must survive the CS rise
  typedef struct packed {
    logic            tgl;
    logic            mid;
    logic [1:0][7:0] hold;
  } frp_hand_s;

  typedef struct packed {
    logic [1:0]                     cs_sync;
    logic [1:0]                     wp_sync;
    logic [1:0]                     tgl_sync;
    logic [1:0]                     mid_sync;
    logic [1:0]                     mode_sync;
    logic [2:0]                     cs_hist;
    logic                           tgl_seen;
    frp_pkg::frp_state_e            state;
    logic [2:0]                     nb;
    logic [7:0]                     op;
    logic [23:0]                    arg;
    logic [9:0]                     page;
    logic [8:0]                     ptr;
    logic [8:0]                     idx;
    logic [8:0]                     rd_at;
    logic                           rd_pend;
    logic                           chk_pend;
    logic [15:0]                    timer;
    logic                           sw_en;
    logic                           wp_on;
    logic [7:0]                     wp_cnt;
    logic [frp_pkg::BUF_BYTES-1:0][7:0] buffer;
    logic [frp_pkg::BUF_BYTES-1:0]  mask;
    frp_pkg::frp_mem_req_s          mem;
    frp_pkg::frp_status_s           status;
  } frp_core_s;

  localparam logic [15:0] PROG_LAST = 16'(PROG_CYCLES - 1);
  localparam logic [7:0]  WPE_LAST  = 8'(frp_pkg::PROTECT_ENABLE_CYCLES - 1);
  localparam logic [7:0]  WPD_LAST  = 8'(frp_pkg::PROTECT_DISABLE_CYCLES - 1);

  function automatic logic frp_prot_hit(input logic [9:0] pg, input logic [7:0][7:0] spr);
    logic [2:0] sec;
    sec = pg[9:frp_pkg::SECT_LSB];
    if (sec != 3'h0) begin
      return spr[sec] == frp_pkg::SECT_PROTECTED;
    end
    if (pg <= frp_pkg::SECT0A_LAST_PG) begin
      return &spr[0][frp_pkg::SECT0A_MSB -: 2];
    end
    return &spr[0][frp_pkg::SECT0B_MSB -: 2];
  endfunction : frp_prot_hit

  frp_lnk_s  lnk_reg, lnk_next;
  frp_hand_s hand_reg, hand_next;
  frp_core_s st_reg, st_next;
  logic      lnk_rst;
  logic [7:0] lnk_byte;

  // Chip select high holds the shifter in reset between frames
  assign lnk_rst  = reset_i | cs_n_i;
  assign lnk_byte = {lnk_reg.shift, si_i};

  always_comb begin
    lnk_next        = lnk_reg;
    hand_next       = hand_reg;
    lnk_next.shift  = lnk_byte[6:0];
    lnk_next.bitcnt = lnk_reg.bitcnt + 3'h1;
    hand_next.mid   = lnk_reg.bitcnt != 3'h7;
    if (lnk_reg.bitcnt == 3'h7) begin
      // Two alternating holds keep each byte stable for two byte times
      hand_next.hold[hand_reg.tgl] = lnk_byte;
      hand_next.tgl                = ~hand_reg.tgl;
    end
  end

  always_ff @(posedge sck_i or posedge lnk_rst) begin
    if (lnk_rst) begin
      lnk_reg <= '0;
    end else begin
      lnk_reg <= lnk_next;
    end
  end

  always_ff @(posedge sck_i or posedge reset_i) begin
    if (reset_i) begin
      hand_reg <= '0;
    end else begin
      hand_reg <= hand_next;
    end
  end

  always_comb begin
    logic [7:0]  rx;
    logic [8:0]  psize;
    logic [23:0] addr;
    logic        wp_low;
    rx     = hand_reg.hold[st_reg.tgl_seen];
    psize  = st_reg.mode_sync[1] ? frp_pkg::PAGE_BYTES_EXT : frp_pkg::PAGE_BYTES_STD;
    addr   = {st_reg.arg[15:0], rx};
    wp_low = ~st_reg.wp_sync[1];

    st_next           = st_reg;
    st_next.cs_sync   = {st_reg.cs_sync[0], cs_n_i};
    st_next.wp_sync   = {st_reg.wp_sync[0], wp_n_i};
    st_next.tgl_sync  = {st_reg.tgl_sync[0], hand_reg.tgl};
    st_next.mid_sync  = {st_reg.mid_sync[0], hand_reg.mid};
    st_next.mode_sync = {st_reg.mode_sync[0], page264_i};
    st_next.cs_hist   = {st_reg.cs_hist[1:0], st_reg.cs_sync[1]};
    st_next.mem.rd    = 1'b0;
    st_next.mem.erase = 1'b0;
    st_next.mem.wr    = 1'b0;
    st_next.rd_pend   = 1'b0;
    st_next.chk_pend  = 1'b0;

    // Pin must hold its new level for the whole delay before it counts
    if (wp_low != st_reg.wp_on) begin
      st_next.wp_cnt = st_reg.wp_cnt + 8'h01;
      if (st_reg.wp_cnt == (st_reg.wp_on ? WPD_LAST : WPE_LAST)) begin
        st_next.wp_on  = wp_low;
        st_next.wp_cnt = 8'h00;
      end
    end else begin
      st_next.wp_cnt = 8'h00;
    end

    if (st_reg.tgl_sync[1] != st_reg.tgl_seen) begin
      st_next.tgl_seen = st_reg.tgl_sync[1];
      // Bytes arriving while busy are dropped
      if (st_reg.state == frp_pkg::ST_IDLE) begin
        if (st_reg.nb != frp_pkg::ADDR_DONE_NB) begin
          st_next.nb = st_reg.nb + 3'h1;
        end
        if (st_reg.nb == 3'h0) begin
          st_next.op   = rx;
          st_next.mask = '0;
        end else if (st_reg.nb != frp_pkg::ADDR_DONE_NB) begin
          st_next.arg = addr;
          if (st_reg.op == frp_pkg::OP_RMW && st_reg.nb == 3'h3) begin
            if (st_reg.mode_sync[1]) begin
              st_next.page = addr[frp_pkg::EXT_PAGE_LSB +: 10];
              st_next.ptr  = addr[8:0];
            end else begin
              st_next.page = addr[frp_pkg::STD_PAGE_LSB +: 10];
              st_next.ptr  = {1'b0, addr[7:0]};
            end
          end
        end else if (st_reg.op == frp_pkg::OP_RMW) begin
          st_next.buffer[st_reg.ptr] = rx;
          st_next.mask[st_reg.ptr]   = 1'b1;
          st_next.ptr = (st_reg.ptr == psize - 9'h001) ? 9'h000 : st_reg.ptr + 9'h001;
        end
      end
    end

    // Acting two cycles late lets a last byte's toggle land first
    if (st_reg.cs_hist[1] && !st_reg.cs_hist[2]) begin
      st_next.nb = 3'h0;
      if (st_reg.state == frp_pkg::ST_IDLE && !st_reg.mid_sync[1] &&
          st_next.nb != st_reg.nb && st_reg.nb == frp_pkg::ADDR_DONE_NB) begin
        if (st_reg.op == frp_pkg::OP_RMW) begin
          // Empty mask means every byte is reloaded: plain page rewrite
          if (!(st_reg.status.protect && frp_prot_hit(st_reg.page, sector_prot_i))) begin
            st_next.state                          = frp_pkg::ST_READ;
            st_next.idx                            = 9'h000;
            st_next.status.busy                    = 1'b1;
            st_next.status.erase_program_error_flag = 1'b0;
          end
        end else if (st_reg.op == frp_pkg::OP_PROT_B1 &&
                     st_reg.arg[23:8] == {frp_pkg::OP_PROT_B2, frp_pkg::OP_PROT_B3}) begin
          if (st_reg.arg[7:0] == frp_pkg::OP_PROT_ENABLE) begin
            st_next.sw_en = 1'b1;
          end else if (st_reg.arg[7:0] == frp_pkg::OP_PROT_DISABLE && !st_reg.wp_on) begin
            st_next.sw_en = 1'b0;
          end
        end
      end
    end

    if (st_reg.rd_pend && !st_reg.mask[st_reg.rd_at]) begin
      st_next.buffer[st_reg.rd_at] = mem_rdata_i;
    end
    if (st_reg.chk_pend && mem_fail_i) begin
      st_next.status.erase_program_error_flag = 1'b1;
    end

    case (st_reg.state)
      frp_pkg::ST_IDLE: begin
      end
      frp_pkg::ST_READ: begin
        st_next.mem.rd       = 1'b1;
        st_next.mem.page     = st_reg.page;
        st_next.mem.byte_sel = st_reg.idx;
        st_next.rd_at        = st_reg.idx;
        st_next.rd_pend      = 1'b1;
        st_next.idx          = st_reg.idx + 9'h001;
        if (st_reg.idx == psize - 9'h001) begin
          st_next.state = frp_pkg::ST_ERASE;
        end
      end
      frp_pkg::ST_ERASE: begin
        st_next.mem.erase = 1'b1;
        st_next.chk_pend  = 1'b1;
        st_next.idx       = 9'h000;
        st_next.state     = frp_pkg::ST_PROG;
      end
      frp_pkg::ST_PROG: begin
        st_next.mem.wr       = 1'b1;
        st_next.mem.byte_sel = st_reg.idx;
        st_next.mem.wdata    = st_reg.buffer[st_reg.idx];
        st_next.chk_pend     = 1'b1;
        st_next.idx          = st_reg.idx + 9'h001;
        st_next.timer        = 16'h0000;
        if (st_reg.idx == psize - 9'h001) begin
          st_next.state = frp_pkg::ST_WAIT;
        end
      end
      frp_pkg::ST_WAIT: begin
        st_next.timer = st_reg.timer + 16'h0001;
        if (st_reg.timer == PROG_LAST) begin
          st_next.status.busy = 1'b0;
          st_next.state       = frp_pkg::ST_IDLE;
        end
      end
      default: begin
        st_next.state = frp_pkg::ST_IDLE;
      end
    endcase

    st_next.status.protect           = st_next.sw_en | st_next.wp_on;
    st_next.status.prot_reg_writable = ~st_next.wp_on;
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_reg                          <= '0;
      st_reg.cs_sync                  <= 2'h3;
      st_reg.wp_sync                  <= 2'h3;
      st_reg.cs_hist                  <= 3'h7;
      st_reg.state                    <= frp_pkg::ST_IDLE;
      st_reg.status.prot_reg_writable <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign mem_o    = st_reg.mem;
  assign status_o = st_reg.status;

endmodule : frp_flash_rmw_protect

/* File: test/frp_flash_rmw_protect_properties.sv */
module frp_flash_rmw_protect_properties (
  input wire logic                  clk_i,
  input wire logic                  reset_i,
  input wire logic                  cs_n_i,
  input wire logic                  wp_n_i,
  input wire logic                  mem_fail_i,
  input wire frp_pkg::frp_mem_req_s mem_o,
  input wire frp_pkg::frp_status_s  status_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence array_pulse_s;
    mem_o.wr || mem_o.erase;
  endsequence
  sequence verify_fail_s;
    array_pulse_s ##1 mem_fail_i;
  endsequence

  erase_in_busy_a: assert property (mem_o.erase |-> status_o.busy)
    else $error("erase pulse outside busy");
  read_in_busy_a: assert property (mem_o.rd |-> status_o.busy)
    else $error("read pulse outside busy");
  write_holds_busy_a: assert property (mem_o.wr |=> status_o.busy [*8])
    else $error("busy dropped before program wait");
  error_set_a: assert property (verify_fail_s |=> status_o.erase_program_error_flag)
    else $error("verify fail not flagged");
  rmw_start_a: assert property ($rose(status_o.busy) |-> $past(cs_n_i, 4)
    ##[0:2] (mem_o.rd && mem_o.byte_sel == 9'h000)) else $error("rewrite start without read of byte zero");
  wp_assert_filter_a: assert property ($fell(status_o.prot_reg_writable) |->
    !$past(wp_n_i, 5) && !$past(wp_n_i, 9)) else $error("protect pin assert not filtered");
  wp_release_filter_a: assert property ($rose(status_o.prot_reg_writable) |->
    $past(wp_n_i, 5) && $past(wp_n_i, 9)) else $error("protect pin release not filtered");
  wp_protects_a: assert property (!status_o.prot_reg_writable |-> status_o.protect)
    else $error("pin asserted but protection off");
endmodule : frp_flash_rmw_protect_properties

bind frp_flash_rmw_protect frp_flash_rmw_protect_properties frp_flash_rmw_protect_properties_inst (
  .clk_i(clk_i), .reset_i(reset_i), .cs_n_i(cs_n_i), .wp_n_i(wp_n_i),
  .mem_fail_i(mem_fail_i), .mem_o(mem_o), .status_o(status_o));

/* File: test/frp_host_model.sv */
module frp_host_model (
  output logic sck_o,
  output logic cs_n_o,
  output logic si_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
  end
  // Mode 0, MSB first; clock stands low between frames
  task automatic frame(input logic [7:0] q[$], input int nbits);
    cs_n_o = 1'b0;
    #47;
    for (int i = 0; i < nbits; i++) begin
      si_o = q[i / 8][7 - i % 8];
      #15 sck_o = 1'b1;
      #15 sck_o = 1'b0;
    end
    #150 cs_n_o = 1'b1;
    si_o = ~si_o;
    #900;
  endtask : frame
endmodule : frp_host_model

/* File: test/frp_flash_rmw_protect_test.sv */
module frp_flash_rmw_protect_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic                  clk_i = 1'b0;
  logic                  reset_i = 1'b1;
  logic                  sck_i;
  logic                  cs_n_i;
  logic                  si_i;
  logic                  wp_n_i = 1'b1;
  logic                  page264_i = 1'b0;
  logic [7:0][7:0]       sector_prot_i = '0;
  logic [7:0]            mem_rdata_i = 8'h00;
  logic                  mem_fail_i = 1'b0;
  logic                  fail_en = 1'b0;
  frp_pkg::frp_mem_req_s mem_o;
  frp_pkg::frp_status_s  status_o;
  logic [7:0]            mem [int];
  int                    wr_cnt = 0;
  int                    miscompares = 0;
  int                    checked = 0;

  always #50 clk_i = ~clk_i;

  frp_flash_rmw_protect #(.PROG_CYCLES(20)) frp_flash_rmw_protect_inst (
    .clk_i(clk_i), .reset_i(reset_i), .sck_i(sck_i), .cs_n_i(cs_n_i), .si_i(si_i),
    .wp_n_i(wp_n_i), .page264_i(page264_i), .sector_prot_i(sector_prot_i),
    .mem_rdata_i(mem_rdata_i), .mem_fail_i(mem_fail_i), .mem_o(mem_o), .status_o(status_o));
  frp_host_model frp_host_model_inst (.sck_o(sck_i), .cs_n_o(cs_n_i), .si_o(si_i));

  // Unwritten array bytes hold a known pattern so merges can be told apart
  function automatic logic [7:0] peek(input int k);
    return mem.exists(k) ? mem[k] : k[7:0] ^ 8'h5A;
  endfunction : peek

  always @(negedge clk_i) begin
    if (mem_o.rd === 1'b1) mem_rdata_i <= peek(int'({mem_o.page, mem_o.byte_sel}));
    if (mem_o.wr === 1'b1) begin
      mem[int'({mem_o.page, mem_o.byte_sel})] = mem_o.wdata;
      wr_cnt++;
    end
    mem_fail_i <= fail_en & (mem_o.wr | mem_o.erase);
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      miscompares++;
    end
  endtask : chk

  task automatic final_report;
    if (miscompares == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report

  task automatic rst(input logic p);
    @(negedge clk_i);
    reset_i <= 1'b1;
    page264_i <= p;
    repeat (10) @(negedge clk_i);
    reset_i <= 1'b0;
    repeat (4) @(negedge clk_i);
  endtask : rst

  task automatic rmw(input logic [23:0] a, input logic [7:0] d[$], input int cut, output logic bz);
    logic [7:0] q[$];
    q = {frp_pkg::OP_RMW, a[23:16], a[15:8], a[7:0]};
    q = {q, d};
    wr_cnt = 0;
    frp_host_model_inst.frame(q, q.size() * 8 - cut);
    bz = status_o.busy;
    repeat (900) begin
      @(negedge clk_i);
      if (status_o.busy !== 1'b1) break;
    end
  endtask : rmw

  task automatic prot(input logic [7:0] last);
    frp_host_model_inst.frame({frp_pkg::OP_PROT_B1, frp_pkg::OP_PROT_B2, frp_pkg::OP_PROT_B3, last}, 32);
    @(negedge clk_i);
  endtask : prot

  task automatic wp(input logic v, input int n);
    wp_n_i <= v;
    repeat (n) @(negedge clk_i);
  endtask : wp

  initial begin
    logic [7:0] none[$];
    logic       bz;
    rst(1'b1);
    rmw({5'h00, 10'h002, 9'h107}, {8'h5C, 8'h3C}, 0, bz);
    chk("busy264", 1, bz);
    chk("wr264", 264, wr_cnt);
    chk("b263", 8'h5C, peek(2 * 512 + 263));
    chk("wrap264", 8'h3C, peek(2 * 512));
    rst(1'b0);
    chk("protect_rst", 0, status_o.protect);
    rmw({6'h00, 10'h003, 8'hFF}, {8'hAA, 8'hBB}, 0, bz);
    chk("wr256", 256, wr_cnt);
    chk("b255", 8'hAA, peek(3 * 512 + 255));
    chk("wrap256", 8'hBB, peek(3 * 512));
    chk("kept_b1", 8'h5B, peek(3 * 512 + 1));
    fail_en = 1'b1;
    rmw({6'h00, 10'h004, 8'h00}, none, 0, bz);
    fail_en = 1'b0;
    chk("wr_auto", 256, wr_cnt);
    chk("auto_b5", 8'h5F, peek(4 * 512 + 5));
    chk("err", 1, status_o.erase_program_error_flag);
    rmw({6'h00, 10'h005, 8'h10}, {8'h11, 8'h22}, 4, bz);
    chk("abort_busy", 0, bz);
    chk("abort_wr", 0, wr_cnt);
    sector_prot_i[1] <= frp_pkg::SECT_PROTECTED;
    prot(frp_pkg::OP_PROT_ENABLE);
    chk("sw_on", 1, status_o.protect);
    rmw({6'h00, 10'h080, 8'h00}, {8'h77}, 0, bz);
    chk("prot_busy", 0, bz);
    chk("prot_wr", 0, wr_cnt);
    prot(frp_pkg::OP_PROT_DISABLE);
    chk("sw_off", 0, status_o.protect);
    wp(1'b0, 5);
    wp(1'b1, 20);
    chk("glitch", 0, status_o.protect);
    wp(1'b0, 30);
    chk("wp_on", 1, status_o.protect);
    chk("wp_ro", 0, status_o.prot_reg_writable);
    prot(frp_pkg::OP_PROT_DISABLE);
    chk("dis_ignored", 1, status_o.protect);
    wp(1'b1, 30);
    chk("wp_off", 0, status_o.protect);
    wp(1'b0, 30);
    prot(frp_pkg::OP_PROT_ENABLE);
    // Disable under the pin must not undo the software enable
    prot(frp_pkg::OP_PROT_DISABLE);
    wp(1'b1, 30);
    chk("sw_kept", 1, status_o.protect);
    chk("wp_rw", 1, status_o.prot_reg_writable);
    prot(frp_pkg::OP_PROT_DISABLE);
    chk("sw_off2", 0, status_o.protect);
    final_report;
  end

  // Whole run is near 2000 cycles; this span leaves ample margin
  initial begin
    #2000000;
    miscompares++;
    final_report;
  end
endmodule : frp_flash_rmw_protect_test
